// ===== sample_buffer.sv
// Small FIFO with valid and ready on both sides, full and empty kept honest.
// Assumes one clock domain; in_ready comes from a flip-flop.
`timescale 1ns/10ps
module sample_buffer #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PTR_W-1:0] wr_ptr_reg;
   logic [PTR_W-1:0] rd_ptr_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic push;
   logic pop;

   // ----------------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------------
   // A word moves only when both sides agree.
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (count_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];

   // Fill level after this cycle's moves.
   always_comb begin
      count_next = count_reg;
      if (push && !pop) begin
         count_next = count_reg + CNT_W'(1);
      end else if (pop && !push) begin
         count_next = count_reg - CNT_W'(1);
      end
   end

   // Pointers, level and registered ready.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + PTR_W'(1);
         end
         count_reg <= count_next;
         in_ready <= (count_next != CNT_W'(DEPTH));
      end
   end

   // Storage, one entry per slot.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

endmodule : sample_buffer

// ===== ssi_master_model.sv
// Serial master that clocks reads from the sensor.
// Assumes the bench calls read_frame.
`timescale 1ns/10ps
module ssi_master_model
   import ssi_monitor_pkg::*;
(
   output logic clk_link,
   input wire logic ssi_data_out
);
   logic base_clk;
   // 6 ns base clock; the link clock stands still outside frames.
   initial begin
      base_clk = 1'b0;
      clk_link = 1'b1;
      forever #3 base_clk = ~base_clk;
   end
   // Half period 288 ns, far above the 70 kHz floor.
   task automatic half_period();
      repeat (48) @(posedge base_clk);
   endtask : half_period
   // Clocks one read and gathers each bit before the next falling edge.
   task automatic read_frame(input int edges, output logic [FRAME_BITS-1:0] word);
      word = '0;
      for (int e = 1; e <= edges; e++) begin
         clk_link = 1'b0;
         half_period();
         clk_link = 1'b1;
         half_period();
         if (e >= 2) word = {word[FRAME_BITS-2:0], ssi_data_out};
      end
   endtask : read_frame
endmodule : ssi_master_model

// ===== ssi_monitor_checker.sv
// Port checks of the position sensor monitor.
// Assumes bench counts: clock loss 2000, alternation 250.
`timescale 1ns/10ps
module ssi_monitor_checker
   import ssi_monitor_pkg::*;
(
   input logic clk_sys,
   input logic sys_rst,
   input logic clk_link,
   input logic ssi_data_out,
   input logic echo_valid,
   input sample_s echo_sample,
   input logic [AMP_W-1:0] echo_amplitude,
   input logic echo_ready,
   input logic internal_fault,
   input logic sync_mode_pin,
   input logic [GAIN_W-1:0] gain,
   input led_s led
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   // ------------------------------------------------------------
   // Helper logic
   // ------------------------------------------------------------
   logic [2:0] link_sync_reg;
   logic [11:0] idle_reg;
   logic low_take;
   // Weak sample taken.
   assign low_take = echo_valid && echo_ready && (echo_amplitude < AMP_LOW);
   // Cycles since the last link rising edge; saturates.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         link_sync_reg <= 3'h0;
         idle_reg <= 12'hfff;
      end else begin
         link_sync_reg <= {link_sync_reg[1:0], clk_link};
         if (link_sync_reg[1] && !link_sync_reg[2]) idle_reg <= 12'h000;
         else if (idle_reg != 12'hfff) idle_reg <= idle_reg + 12'h001;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   sequence s_fault_red;
      internal_fault && led == 2'b10;
   endsequence
   sequence s_fault_green;
      ##2 (led == 2'b01 || led == 2'b10);
   endsequence
   property p_reset_dark;
      disable iff (1'b0) sys_rst |-> led == 2'b00 && gain == GAIN_RESET && ssi_data_out && echo_ready;
   endproperty
   property p_first_red;
      $fell(sys_rst) && !internal_fault |=> led == 2'b10;
   endproperty
   property p_gain_step;
      $changed(gain) |-> gain == $past(gain) + 4'h1 || gain == $past(gain) - 4'h1;
   endproperty
   property p_gain_up;
      $changed(gain) && gain > $past(gain) |-> $past(low_take) || $past(low_take, 2);
   endproperty
   property p_fault_alt;
      s_fault_red |-> ##[1:260] led == 2'b01;
   endproperty
   property p_fault_colour;
      internal_fault |-> s_fault_green;
   endproperty
   property p_data_on_edge;
      $changed(ssi_data_out) |-> clk_link;
   endproperty
   property p_green_clock;
      led == 2'b01 && !internal_fault |-> idle_reg < 12'd2010;
   endproperty
   property p_yellow_idle;
      idle_reg > 12'd2010 && !internal_fault && !$past(sys_rst) |-> led == 2'b11 || led == 2'b10;
   endproperty
   a_reset_dark: assert property (p_reset_dark) else $error("reset outputs wrong");
   a_first_red: assert property (p_first_red) else $error("no red after reset");
   a_gain_step: assert property (p_gain_step) else $error("gain jumped");
   a_gain_up: assert property (p_gain_up) else $error("gain rose unasked");
   a_fault_alt: assert property (p_fault_alt) else $error("no fault green");
   a_fault_colour: assert property (p_fault_colour) else $error("fault colour wrong");
   a_data_on_edge: assert property (p_data_on_edge) else $error("data off link edge");
   a_green_clock: assert property (p_green_clock) else $error("green, no clock");
   a_yellow_idle: assert property (p_yellow_idle) else $error("no yellow");
endmodule : ssi_monitor_checker

bind ssi_position_status_monitor ssi_monitor_checker chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .clk_link(clk_link), .ssi_data_out(ssi_data_out), .echo_valid(echo_valid), .echo_sample(echo_sample),
   .echo_amplitude(echo_amplitude), .echo_ready(echo_ready), .internal_fault(internal_fault),
   .sync_mode_pin(sync_mode_pin), .gain(gain), .led(led));

// ===== ssi_monitor_pkg.sv
// Shared constants and types of the position sensor status and readout block.
// Assumes a 20 MHz system clock; every cycle count below is derived from it.
package ssi_monitor_pkg;

   // ----------------------------------------------------------------------
   // Clock and widths
   // ----------------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int POS_W = 24;
   localparam int FRAME_BITS = 24;
   localparam int PULSES_PER_FRAME = FRAME_BITS + 1;
   localparam int LINK_CNT_W = 8;
   localparam int TIMER_W = 25;
   localparam int GAIN_W = 4;
   localparam int AMP_W = 8;

   // ----------------------------------------------------------------------
   // Signal strength window and gain reset value
   // ----------------------------------------------------------------------
   localparam logic [AMP_W-1:0] AMP_LOW = 8'h60;
   localparam logic [AMP_W-1:0] AMP_HIGH = 8'ha0;
   localparam logic [GAIN_W-1:0] GAIN_RESET = 4'h8;
   localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hf;

   // ----------------------------------------------------------------------
   // Times in microseconds and their cycle counts
   // ----------------------------------------------------------------------
   localparam int GAP_TIME_US = 20;
   localparam int CLK_LOSS_TIME_US = 100000;
   localparam int TUNE_TIME_US = 500000;
   localparam int ECHO_LOSS_TIME_US = 100000;
   localparam int FLASH_MAX_US = 1000000;
   localparam int FLASH_MIN_US = 120000;
   localparam int FLASH_STEP_US = 110000;
   localparam int FLASH_ON_US = 50000;
   localparam int ALT_HALF_US = 250000;
   localparam int GAP_CYC = GAP_TIME_US * CLK_MHZ;
   localparam int CLK_LOSS_CYC = CLK_LOSS_TIME_US * CLK_MHZ;
   localparam int TUNE_CYC = TUNE_TIME_US * CLK_MHZ;
   localparam int ECHO_LOSS_CYC = ECHO_LOSS_TIME_US * CLK_MHZ;
   localparam int FLASH_MAX_CYC = FLASH_MAX_US * CLK_MHZ;
   localparam int FLASH_MIN_CYC = FLASH_MIN_US * CLK_MHZ;
   localparam int FLASH_STEP_CYC = FLASH_STEP_US * CLK_MHZ;
   localparam int FLASH_ON_CYC = FLASH_ON_US * CLK_MHZ;
   localparam int ALT_HALF_CYC = ALT_HALF_US * CLK_MHZ;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [POS_W-1:0] position;
   } sample_s;

   typedef struct packed {
      logic red;
      logic green;
   } led_s;

   typedef enum logic [1:0] {
      ST_TUNE,
      ST_RUN,
      ST_NO_ELEMENT,
      ST_FAULT
   } mon_state_e;

endpackage : ssi_monitor_pkg

// ===== ssi_position_status_monitor.sv
// Start-up tuning, supervision, indicator and serial readout of a position sensor.
// Assumes a measurement front end on clk_sys and an external master that drives clk_link.
//
// Behaviour
// - After power-up the block tunes gain by itself, no configuration needed.
// - Indicator is dark while unpowered and during reset.
// - Steady green when element is present and master clock is active.
// - Yellow when no master clock activity is seen.
// - No element: red indicator and position zero sent in frames.
// - Internal error: alternating red and green flashing.
// - Synchronous mode, stale data: green with yellow flashes, 1 s to 0.12 s.
// - Pulse count differs from frame length: green with brief red flashes.
// - Only a power cycle re-runs tuning and clears a missing element.
`timescale 1ns/10ps
module ssi_position_status_monitor
   import ssi_monitor_pkg::*;
#(
   parameter int CLK_LOSS_CYCLES = CLK_LOSS_CYC,
   parameter int TUNE_CYCLES = TUNE_CYC,
   parameter int ECHO_LOSS_CYCLES = ECHO_LOSS_CYC,
   parameter int FLASH_MAX_CYCLES = FLASH_MAX_CYC,
   parameter int FLASH_MIN_CYCLES = FLASH_MIN_CYC,
   parameter int FLASH_STEP_CYCLES = FLASH_STEP_CYC,
   parameter int FLASH_ON_CYCLES = FLASH_ON_CYC,
   parameter int ALT_HALF_CYCLES = ALT_HALF_CYC,
   parameter int BUF_DEPTH = 2
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic clk_link,
   output logic ssi_data_out,
   input wire logic echo_valid,
   input wire sample_s echo_sample,
   input wire logic [AMP_W-1:0] echo_amplitude,
   output logic echo_ready,
   input wire logic internal_fault,
   input wire logic sync_mode_pin,
   output logic [GAIN_W-1:0] gain,
   output led_s led
);
   localparam int IDX_W = $clog2(FRAME_BITS + 1);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   logic [LINK_CNT_W-1:0] link_bin_reg;
   logic [LINK_CNT_W-1:0] link_bin_next;
   logic [LINK_CNT_W-1:0] link_gray_reg;
   logic [IDX_W-1:0] bit_idx_reg;
   logic [LINK_CNT_W-1:0] gray_s1_reg;
   logic [LINK_CNT_W-1:0] gray_s2_reg;
   logic [LINK_CNT_W-1:0] edge_cnt_reg;
   logic [LINK_CNT_W-1:0] edge_cnt_prev_reg;
   logic [LINK_CNT_W-1:0] frame_base_reg;
   logic [LINK_CNT_W-1:0] pulses;
   logic edge_seen;
   logic [TIMER_W-1:0] idle_cnt_reg;
   logic gap_reg;
   logic gap_next;
   logic frame_end;
   logic clk_lost_reg;
   logic [POS_W-1:0] frame_word_reg;
   logic mode_s1_reg;
   logic mode_s2_reg;
   logic sync_mode_reg;
   logic [1:0] strap_age_reg;
   mon_state_e state_reg;
   logic [TIMER_W-1:0] tune_cnt_reg;
   logic [TIMER_W-1:0] echo_idle_reg;
   logic echo_take;
   logic buf_in_valid;
   logic buf_out_valid;
   logic buf_out_ready;
   sample_s buf_out_data;
   logic [1:0] flash_event;
   logic [1:0] flash_active;
   logic [1:0] flash_lit;
   logic [TIMER_W-1:0] alt_cnt_reg;
   logic alt_reg;
   led_s led_next;

   // ----------------------------------------------------------------------
   // Link domain: clocked by the master's serial clock
   // ----------------------------------------------------------------------
   assign link_bin_next = link_bin_reg + LINK_CNT_W'(1);

   // Free-running gray edge counter; one step per master clock rising edge.
   always_ff @(posedge clk_link or posedge sys_rst) begin
      if (sys_rst) begin
         link_bin_reg <= '0;
         link_gray_reg <= '0;
      end else begin
         link_bin_reg <= link_bin_next;
         link_gray_reg <= link_bin_next ^ (link_bin_next >> 1);
      end
   end

   // Serial shifter, held idle high by the frame gap flag from the system side.
   // The first rising edge of a read lands while the gap flag is still set and only opens the frame.
   always_ff @(posedge clk_link or posedge gap_reg) begin
      if (gap_reg) begin
         bit_idx_reg <= '0;
         ssi_data_out <= 1'b1;
      end else if (bit_idx_reg < IDX_W'(FRAME_BITS)) begin
         ssi_data_out <= frame_word_reg[IDX_W'(FRAME_BITS - 1) - bit_idx_reg];
         bit_idx_reg <= bit_idx_reg + IDX_W'(1);
      end else begin
         ssi_data_out <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Crossing of the edge count into the system domain
   // ----------------------------------------------------------------------
   function automatic logic [LINK_CNT_W-1:0] gray_to_bin(input logic [LINK_CNT_W-1:0] g);
      logic [LINK_CNT_W-1:0] b;
      b = '0;
      for (int i = LINK_CNT_W - 1; i >= 0; i--) begin
         b[i] = g[i] ^ ((i == LINK_CNT_W - 1) ? 1'b0 : b[i + 1]);
      end
      return b;
   endfunction : gray_to_bin

   // Two-flop synchroniser for the gray count, then conversion to binary.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gray_s1_reg <= '0;
         gray_s2_reg <= '0;
         edge_cnt_reg <= '0;
         edge_cnt_prev_reg <= '0;
      end else begin
         gray_s1_reg <= link_gray_reg;
         gray_s2_reg <= gray_s1_reg;
         edge_cnt_reg <= gray_to_bin(gray_s2_reg);
         edge_cnt_prev_reg <= edge_cnt_reg;
      end
   end

   assign edge_seen = (edge_cnt_reg != edge_cnt_prev_reg);
   assign gap_next = edge_seen ? 1'b0 : (gap_reg || (idle_cnt_reg >= TIMER_W'(GAP_CYC - 1)));
   assign frame_end = gap_next && !gap_reg;
   assign pulses = edge_cnt_reg - frame_base_reg;

   // ----------------------------------------------------------------------
   // Clock activity, frame gap and clock loss
   // ----------------------------------------------------------------------
   // Idle timer restarts on every master rising edge and saturates at the loss time.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         idle_cnt_reg <= '0;
      end else if (edge_seen) begin
         idle_cnt_reg <= '0;
      end else if (idle_cnt_reg < TIMER_W'(CLK_LOSS_CYCLES)) begin
         idle_cnt_reg <= idle_cnt_reg + TIMER_W'(1);
      end
   end

   // Gap flag marks the quiet time between reads; it also holds the shifter idle.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gap_reg <= 1'b1;
      end else begin
         gap_reg <= gap_next;
      end
   end

   // Master clock counted missing until edges arrive, and again after a long silence.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         clk_lost_reg <= 1'b1;
      end else if (edge_seen) begin
         clk_lost_reg <= 1'b0;
      end else if (idle_cnt_reg >= TIMER_W'(CLK_LOSS_CYCLES)) begin
         clk_lost_reg <= 1'b1;
      end
   end

   // Edge count at the end of each read, to measure the pulses of the next one.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         frame_base_reg <= '0;
      end else if (frame_end) begin
         frame_base_reg <= edge_cnt_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Mode strap
   // ----------------------------------------------------------------------
   // The strap pin is synchronised and caught once after reset is released.
   // The second flop holds the pin only from the second edge on, so the catch waits for the third edge.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         mode_s1_reg <= 1'b0;
         mode_s2_reg <= 1'b0;
         sync_mode_reg <= 1'b0;
         strap_age_reg <= 2'h0;
      end else begin
         mode_s1_reg <= sync_mode_pin;
         mode_s2_reg <= mode_s1_reg;
         if (strap_age_reg != 2'h3) begin
            strap_age_reg <= strap_age_reg + 2'h1;
         end
         if (strap_age_reg == 2'h2) begin
            sync_mode_reg <= mode_s2_reg;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Start-up tuning and supervision
   // ----------------------------------------------------------------------
   assign echo_take = echo_valid && echo_ready;

   // Operating state; only reset leaves the fault state, and only reset or a fault leaves the no-element state.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_TUNE;
      end else if (internal_fault) begin
         state_reg <= ST_FAULT;
      end else begin
         unique case (state_reg)
            ST_TUNE: begin
               if (echo_take && echo_amplitude >= AMP_LOW && echo_amplitude <= AMP_HIGH) begin
                  state_reg <= ST_RUN;
               end else if (tune_cnt_reg >= TIMER_W'(TUNE_CYCLES - 1)) begin
                  state_reg <= ST_NO_ELEMENT;
               end
            end
            ST_RUN: begin
               if (echo_idle_reg >= TIMER_W'(ECHO_LOSS_CYCLES - 1)) begin
                  state_reg <= ST_NO_ELEMENT;
               end
            end
            ST_NO_ELEMENT: state_reg <= ST_NO_ELEMENT;
            ST_FAULT: state_reg <= ST_FAULT;
         endcase
      end
   end

   // Gain steps toward the amplitude window while tuning, then stays fixed.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         gain <= GAIN_RESET;
      end else if (state_reg == ST_TUNE && echo_take) begin
         if (echo_amplitude < AMP_LOW && gain != GAIN_MAX) begin
            gain <= gain + GAIN_W'(1);
         end else if (echo_amplitude > AMP_HIGH && gain != '0) begin
            gain <= gain - GAIN_W'(1);
         end
      end
   end

   // Tuning timeout and loss-of-echo timer; a full buffer is not counted as loss.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tune_cnt_reg <= '0;
         echo_idle_reg <= '0;
      end else begin
         if (state_reg == ST_TUNE) begin
            tune_cnt_reg <= tune_cnt_reg + TIMER_W'(1);
         end
         if (state_reg != ST_RUN || echo_take || !echo_ready) begin
            echo_idle_reg <= '0;
         end else begin
            echo_idle_reg <= echo_idle_reg + TIMER_W'(1);
         end
      end
   end

   // ----------------------------------------------------------------------
   // Sample buffer and frame word
   // ----------------------------------------------------------------------
   assign buf_in_valid = echo_valid && (state_reg == ST_RUN);
   assign buf_out_ready = frame_end && (state_reg == ST_RUN);

   sample_buffer #(
      .WIDTH($bits(sample_s)),
      .DEPTH(BUF_DEPTH)
   ) u_sample_buffer (
      .clk(clk_sys),
      .rst(sys_rst),
      .in_valid(buf_in_valid),
      .in_ready(echo_ready),
      .in_data(echo_sample),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data)
   );

   // The word for the next read is taken at the end of each read, in the gap.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         frame_word_reg <= '0;
      end else if (frame_end) begin
         if (state_reg != ST_RUN) begin
            frame_word_reg <= '0;
         end else if (buf_out_valid) begin
            frame_word_reg <= buf_out_data.position;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Flash indications: channel 0 pulse count, channel 1 synchronisation
   // ----------------------------------------------------------------------
   assign flash_event[0] = frame_end && (pulses != LINK_CNT_W'(PULSES_PER_FRAME));
   assign flash_event[1] = frame_end && sync_mode_reg && !buf_out_valid && (state_reg == ST_RUN);

   // Each channel holds for one long interval after its last event; repeated
   // events shorten the flash interval step by step down to the minimum.
   for (genvar ch = 0; ch < 2; ch++) begin : g_flash
      logic [TIMER_W-1:0] hold_reg;
      logic [TIMER_W-1:0] period_reg;
      logic [TIMER_W-1:0] phase_reg;
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            hold_reg <= '0;
            period_reg <= TIMER_W'(FLASH_MAX_CYCLES);
            phase_reg <= '0;
         end else if (flash_event[ch]) begin
            hold_reg <= TIMER_W'(FLASH_MAX_CYCLES);
            if (hold_reg == '0) begin
               period_reg <= TIMER_W'(FLASH_MAX_CYCLES);
               phase_reg <= '0;
            end else if (period_reg >= TIMER_W'(FLASH_MIN_CYCLES + FLASH_STEP_CYCLES)) begin
               period_reg <= period_reg - TIMER_W'(FLASH_STEP_CYCLES);
            end else begin
               period_reg <= TIMER_W'(FLASH_MIN_CYCLES);
            end
         end else if (hold_reg != '0) begin
            hold_reg <= hold_reg - TIMER_W'(1);
            phase_reg <= (phase_reg >= period_reg - TIMER_W'(1)) ? '0 : phase_reg + TIMER_W'(1);
         end
      end
      assign flash_active[ch] = (hold_reg != '0);
      assign flash_lit[ch] = (phase_reg < TIMER_W'(FLASH_ON_CYCLES));
   end

   // Alternation timer for the internal error pattern.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         alt_cnt_reg <= '0;
         alt_reg <= 1'b0;
      end else if (alt_cnt_reg >= TIMER_W'(ALT_HALF_CYCLES - 1)) begin
         alt_cnt_reg <= '0;
         alt_reg <= !alt_reg;
      end else begin
         alt_cnt_reg <= alt_cnt_reg + TIMER_W'(1);
      end
   end

   // ----------------------------------------------------------------------
   // Indicator
   // ----------------------------------------------------------------------
   // Patterns by priority: fault, tuning or no element, clock loss, count, sync, good.
   always_comb begin
      led_next = '{red: 1'b0, green: 1'b1};
      if (state_reg == ST_FAULT) begin
         led_next = '{red: !alt_reg, green: alt_reg};
      end else if (state_reg != ST_RUN) begin
         led_next = '{red: 1'b1, green: 1'b0};
      end else if (clk_lost_reg) begin
         led_next = '{red: 1'b1, green: 1'b1};
      end else if (flash_active[0] && flash_lit[0]) begin
         led_next = '{red: 1'b1, green: 1'b0};
      end else if (flash_active[1] && flash_lit[1]) begin
         led_next = '{red: 1'b1, green: 1'b1};
      end
   end

   // Indicator register; dark while reset is held.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         led <= '{red: 1'b0, green: 1'b0};
      end else begin
         led <= led_next;
      end
   end

endmodule : ssi_position_status_monitor

// ===== ssi_position_status_monitor_bench.sv
// Self-checking bench of the sensor monitor.
// Assumes short counts and a 20 MHz clock.
`timescale 1ns/10ps
module ssi_position_status_monitor_bench import ssi_monitor_pkg::*;;
   logic clk_sys, sys_rst, clk_link, ssi_data_out, echo_valid, echo_ready, internal_fault, sync_mode_pin;
   sample_s echo_sample;
   logic [AMP_W-1:0] echo_amplitude;
   logic [GAIN_W-1:0] gain;
   led_s led;
   logic [31:0] seed;
   logic [FRAME_BITS-1:0] word, w;
   int num_errors, checks_done;
   ssi_position_status_monitor #(.CLK_LOSS_CYCLES(2000), .TUNE_CYCLES(500), .ECHO_LOSS_CYCLES(4000),
      .FLASH_MAX_CYCLES(1000), .ALT_HALF_CYCLES(250)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .clk_link(clk_link), .ssi_data_out(ssi_data_out), .echo_valid(echo_valid), .echo_sample(echo_sample),
      .echo_amplitude(echo_amplitude), .echo_ready(echo_ready), .internal_fault(internal_fault),
      .sync_mode_pin(sync_mode_pin), .gain(gain), .led(led));
   ssi_master_model master_u (.clk_link(clk_link), .ssi_data_out(ssi_data_out));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // System clock at 50 ns.
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : next_rand
   function automatic logic [GAIN_W-1:0] exp_gain(input logic [GAIN_W-1:0] g, input int n);
      return (int'(g) + n > int'(GAIN_MAX)) ? GAIN_MAX : GAIN_W'(int'(g) + n);
   endfunction : exp_gain
   task automatic tick();
      @(posedge clk_sys);
      #2;
   endtask : tick
   task automatic chk(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   task automatic wait_led(input logic [1:0] v, input int bound, input string msg);
      logic found = 1'b0;
      for (int i = 0; i < bound && !found; i++) begin
         tick();
         found = (led === v);
      end
      chk(found, msg);
   endtask : wait_led
   // One read plus its closing gap.
   task automatic read(input int edges);
      master_u.read_frame(edges, word);
      repeat (420) tick();
   endtask : read
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (3) tick();
      chk(led === 2'b00 && gain === GAIN_RESET && ssi_data_out === 1'b1, "reset outputs wrong");
      sys_rst = 1'b0;
   endtask : do_reset
   // Random word, in-window amplitude.
   task automatic new_sample();
      seed = next_rand(seed);
      w = seed[FRAME_BITS-1:0];
      echo_sample = w;
      echo_amplitude = AMP_LOW + seed[31:24] % 8'h41;
   endtask : new_sample
   task automatic results();
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      sys_rst = 1'b1;
      echo_valid = 1'b0;
      echo_sample = '0;
      echo_amplitude = 8'h00;
      internal_fault = 1'b0;
      sync_mode_pin = 1'b0;
      num_errors = 0;
      checks_done = 0;
      seed = 32'h3b7bba0d;
      w = '0;
      tick();
      do_reset();
      echo_valid = 1'b1;
      echo_amplitude = 8'h40;
      tick();
      new_sample();
      repeat (2) tick();
      chk(gain === exp_gain(GAIN_RESET, 1), "gain not raised");
      chk(led === 2'b11, "no yellow");
      repeat (3) read(25);
      chk(word === w, "frame word wrong");
      chk(led === 2'b01, "not green");
      read(20);
      wait_led(2'b10, 1100, "no red flash");
      internal_fault = 1'b1;
      wait_led(2'b01, 300, "fault green missing");
      wait_led(2'b10, 300, "fault red missing");
      internal_fault = 1'b0;
      sync_mode_pin = 1'b1;
      echo_amplitude = 8'h10;
      do_reset();
      repeat (20) tick();
      chk(gain === exp_gain(GAIN_RESET, 20), "gain not at ceiling");
      repeat (600) tick();
      chk(led === 2'b10, "no red without element");
      read(25);
      chk(word === '0, "position not zero");
      new_sample();
      do_reset();
      repeat (2) read(25);
      chk(word === w, "word wrong");
      chk(led === 2'b01, "not green");
      echo_valid = 1'b0;
      repeat (3) read(25);
      wait_led(2'b11, 1100, "no yellow flash");
      results();
   end
endmodule : ssi_position_status_monitor_bench
